// >>> core/orcd_map.svh
// Purpose: constants of the odd ratio clock divider
// Assumes: 50 MHz system clock
// Notes: loss count in system clock cycles, half counts in input half periods
`ifndef ORCD_MAP_SVH
`define ORCD_MAP_SVH

`define ORCD_CLK_MHZ 50
`define ORCD_HALF_DIV3 4'h3
`define ORCD_HALF_DIV5 4'h5
`define ORCD_PH_W 4
`define ORCD_LOSS_TIME_NS 1000
`define ORCD_LOSS_CYCLES ((`ORCD_LOSS_TIME_NS * `ORCD_CLK_MHZ) / 1000)
`define ORCD_LOSS_W 8
`define ORCD_SEL_DIV5 1'b1

`endif

// >>> core/orcd_pkg.sv
// Purpose: types of the odd ratio clock divider
// Assumes: nothing
// Notes: one-hot state codes
package orcd_pkg;
    typedef enum logic [3:0] {
        ORCD_ST_IDLE  = 4'b0001,
        ORCD_ST_ARM_R = 4'b0010,
        ORCD_ST_ARM_F = 4'b0100,
        ORCD_ST_RUN   = 4'b1000
    } orcd_state_t;
endpackage : orcd_pkg

// >>> core/orcd_sync.sv
// Purpose: three stage input synchroniser with agreement filter
// Assumes: input from another clock domain or a pin
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
module orcd_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // stage one feeds stage two only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out <= RESET_VAL;
        end else if (s2_reg == s3_reg) begin
            sync_out <= s3_reg;
        end
    end
endmodule : orcd_sync

// >>> core/orcd_divider.sv
// Purpose: divide a sampled input clock by three or five with a clean enable
// Assumes: input clock well below a quarter of clk; ratio select static while enabled
// Notes: loss of input edges freezes the output at its current level
`timescale 1ns/1ps
`include "orcd_map.svh"
module orcd_divider (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_clk,
    input wire logic enable,
    input wire logic div_sel,
    output logic clk_out,
    output logic input_lost
);
    import orcd_pkg::*;

    // half input periods spent high; period is twice this
    function automatic logic [`ORCD_PH_W-1:0] half_count(input logic sel);
        half_count = (sel == `ORCD_SEL_DIV5) ? `ORCD_HALF_DIV5 : `ORCD_HALF_DIV3;
    endfunction : half_count

    logic in_s;
    logic en_s;
    logic in_d_reg;
    logic rise;
    logic fall;
    logic edge_seen;
    logic [`ORCD_LOSS_W-1:0] loss_cnt_reg;
    orcd_state_t state_reg;
    logic [`ORCD_PH_W-1:0] ph_reg;
    logic [`ORCD_PH_W-1:0] ph_next;
    logic [`ORCD_PH_W-1:0] half_reg;
    logic stop_pend_reg;

    orcd_sync #(.RESET_VAL(1'b0)) u_sync_clk (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(in_clk),
        .sync_out(in_s)
    );

    // pull-up behaviour: reset state is enabled
    orcd_sync #(.RESET_VAL(1'b1)) u_sync_en (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(enable),
        .sync_out(en_s)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_d_reg <= 1'b0;
        end else begin
            in_d_reg <= in_s;
        end
    end

    assign rise = in_s & ~in_d_reg;
    assign fall = ~in_s & in_d_reg;
    assign edge_seen = rise | fall;

    // digital stand-in for the swing detector: no edge for the timeout means lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loss_cnt_reg <= '0;
            input_lost <= 1'b0;
        end else if (edge_seen) begin
            loss_cnt_reg <= '0;
            input_lost <= 1'b0;
        end else if (loss_cnt_reg == `ORCD_LOSS_W'(`ORCD_LOSS_CYCLES - 1)) begin
            input_lost <= 1'b1;
        end else begin
            loss_cnt_reg <= loss_cnt_reg + `ORCD_LOSS_W'(1);
        end
    end

    assign ph_next = (ph_reg == ((half_reg << 1) - `ORCD_PH_W'(1))) ? '0
                   : ph_reg + `ORCD_PH_W'(1);

    // state only moves on input edges, so a stopped input freezes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ORCD_ST_IDLE;
            ph_reg <= '0;
            half_reg <= `ORCD_HALF_DIV3;
            stop_pend_reg <= 1'b0;
            clk_out <= 1'b0;
        end else if (edge_seen && !input_lost) begin
            case (state_reg)
                ORCD_ST_IDLE: begin
                    clk_out <= 1'b0;
                    stop_pend_reg <= 1'b0;
                    half_reg <= half_count(div_sel);
                    if (en_s) begin
                        state_reg <= ORCD_ST_ARM_R;
                    end
                end
                ORCD_ST_ARM_R: begin
                    if (!en_s) begin
                        state_reg <= ORCD_ST_IDLE;
                    end else if (rise) begin
                        state_reg <= ORCD_ST_ARM_F;
                    end
                end
                ORCD_ST_ARM_F: begin
                    if (!en_s) begin
                        state_reg <= ORCD_ST_IDLE;
                    end else if (fall) begin
                        // next rise wraps the phase to zero and raises the output
                        state_reg <= ORCD_ST_RUN;
                        ph_reg <= (half_reg << 1) - `ORCD_PH_W'(1);
                    end
                end
                ORCD_ST_RUN: begin
                    ph_reg <= ph_next;
                    clk_out <= (ph_next < half_reg);
                    if (rise && !en_s) begin
                        stop_pend_reg <= 1'b1;
                    end
                    // hold only at an output falling edge, never mid pulse
                    if (stop_pend_reg && ph_next == half_reg) begin
                        state_reg <= ORCD_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ORCD_ST_IDLE;
                    clk_out <= 1'b0;
                end
            endcase
        end
    end
endmodule : orcd_divider

// >>> tb/orcd_src.sv
// Purpose: input clock source model
// Assumes: half period in clk cycles
// Notes: holds its level while stopped
`timescale 1ns/1ps
module orcd_src (
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] half,
    output logic in_clk = 1'b0
);
    logic [3:0] n_reg = 4'h0;
    // a stopped source stays static, the failure the guard must absorb
    always @(posedge clk) if (run) n_reg <= (n_reg + 4'h1 >= half) ? 4'h0 : n_reg + 4'h1;
    always @(posedge clk) if (run && n_reg + 4'h1 >= half) in_clk <= !in_clk;
endmodule : orcd_src

// >>> tb/orcd_divider_properties.sv
// Purpose: port checker of the divider
// Assumes: input half periods over six clk
// Notes: sync delay cancels in edge counts
`timescale 1ns/1ps
module orcd_divider_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_clk,
    input wire logic enable,
    input wire logic div_sel,
    input wire logic clk_out,
    input wire logic input_lost
);
    logic [7:0] q;
    logic [2:0] hc;
    logic [2:0] ee;
    logic [8:0] e;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk) q <= (!rst_n || $changed(in_clk)) ? 8'h00 : q + 8'(q != 8'hFF);
    always_ff @(posedge clk) hc <= (!rst_n || !clk_out) ? 3'h0 : hc + 3'($changed(in_clk));
    always_ff @(posedge clk) ee <= (!rst_n || !enable) ? 3'h0 :
        ee + 3'($changed(in_clk) && ee != 3'h7);
    always_ff @(posedge clk) e <= (!rst_n || enable) ? 9'h000 : e + 9'(e != 9'h1FF);
    sequence pin_edge;
        $changed(in_clk);
    endsequence
    edge_cause_a: assert property ($changed(clk_out) |-> q < 8'h09)
        else $error("output moved without input edge");
    div3_width_a: assert property ($fell(clk_out) && !div_sel |-> hc == 3'h3)
        else $error("divide by three pulse width");
    div5_width_a: assert property ($fell(clk_out) && div_sel |-> hc == 3'h5)
        else $error("divide by five pulse width");
    enable_start_a: assert property ($rose(clk_out) && enable |-> ee > 3'h2)
        else $error("output started too early");
    disable_hold_a: assert property (e > 9'h11F |-> !clk_out)
        else $error("output not held after disable");
    quiet_lost_a: assert property (q > 8'h3B |-> input_lost)
        else $error("loss not flagged");
    lost_freeze_a: assert property (input_lost |=> $stable(clk_out))
        else $error("output moved during loss");
    lost_clear_a: assert property (pin_edge ##0 input_lost |-> ##[1:8] !input_lost)
        else $error("loss flag not cleared");
endmodule : orcd_divider_properties
bind orcd_divider orcd_divider_properties chk (.clk, .rst_n, .in_clk, .enable, .div_sel,
    .clk_out, .input_lost);

// >>> tb/test_orcd_divider.sv
// Purpose: self-checking bench of the divider
// Assumes: input half periods of 7 to 10 clk
// Notes: pulse widths counted in input edges
`timescale 1ns/1ps
module test_orcd_divider;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic enable = 1'b1;
    logic div_sel = 1'b0;
    logic run = 1'b1;
    logic [3:0] half = 4'h8;
    logic in_clk;
    logic clk_out;
    logic input_lost;
    logic [7:0] hi;
    logic [7:0] lo;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'he075e225;
    always #10 clk = !clk;
    orcd_src src (.clk, .run, .half, .in_clk);
    orcd_divider DUT (.clk, .rst_n, .in_clk, .enable, .div_sel, .clk_out, .input_lost);
    function automatic logic [7:0] nh(input logic s);
        return s ? 8'h05 : 8'h03;
    endfunction : nh
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // bounded, so a dead output cannot hang the run
    task automatic upto(input logic lvl, output logic [7:0] n);
        logic p;
        n = 8'h00;
        for (int t = 0; t < 999 && clk_out !== lvl; t++) begin
            p = in_clk;
            @(negedge clk);
            n += 8'(in_clk != p);
        end
        check("clk_out level", 8'(lvl), 8'(clk_out));
    endtask : upto
    always @(negedge clk) begin
        cycles++;
        if (cycles > 30000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            enable = 1'b0;
            repeat (300) @(negedge clk);
            check("held clk_out", 8'h00, 8'(clk_out));
            div_sel = i[0];
            half = 4'h7 + 4'($unsigned($random(seed)) % 4);
            enable = 1'b1;
            upto(1'b1, hi);
            upto(1'b0, hi);
            upto(1'b1, lo);
            check("high edges", nh(div_sel), hi);
            check("low edges", nh(div_sel), lo);
        end
        upto(1'b0, hi);
        run = 1'b0;
        repeat (80) @(negedge clk);
        check("lost flag", 8'h01, 8'(input_lost));
        check("frozen clk_out", 8'h00, 8'(clk_out));
        run = 1'b1;
        repeat (40) @(negedge clk);
        check("lost cleared", 8'h00, 8'(input_lost));
        summarize();
    end
endmodule : test_orcd_divider
